// >>> rtl/eer_defs.vh
/*
  Shared constants of the serial EEPROM target: widths, bit-phase counts,
  control byte field positions and write cycle timing.
  Assumes inclusion by bare name from the rtl/ files of this block.
*/
// What this block does
// - No acknowledge at all while write runs.
// - Stop after write command starts write cycle.
// - Acknowledge polling byte once write cycle ends.
// - Direction bit one selects a read.
// - Pointer holds last accessed address plus one.
// - Acknowledge read byte, send data MSB first.
// - Unacknowledged read byte: stop driving data.
// - Dummy write loads pointer, starts no write.
// - After repeated Start, acknowledge and send data.
// - Random read leaves pointer after returned byte.
// - Master acknowledge fetches next byte at once.
// - Pointer increments after every byte operation.
// - Pointer wraps from top location to zero.
// - Respond only on matching type and selects.
// - Address high byte first, top bit ignored.
`ifndef EER_DEFS_VH
`define EER_DEFS_VH

`define EER_ADDR_W 15
`define EER_DATA_W 8
`define EER_CNT_W 4
`define EER_BIT_ACK 4'h8
`define EER_BIT_END 4'h9
`define EER_CNT_ONE 4'h1
`define EER_CNT_ZERO 4'h0
`define EER_CTRL_RW 0
`define EER_CTRL_CS_HI 3
`define EER_CTRL_CS_LO 1
`define EER_CTRL_TYPE_HI 7
`define EER_CTRL_TYPE_LO 4
`define EER_ADRH_HI 6
`define EER_CLK_NS 5
`define EER_TWC_NS 5000000
`define EER_TWC_W 20
// Write cycle length in clock cycles, sized to the timer width.
`define EER_TWC_CYC 20'hF4240

`endif

// >>> rtl/eer_mem.v
/*
  Byte array of the serial EEPROM with one write port and a registered read.
  Assumes a single clock; the read data trails the read address by one edge.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eer_defs.vh"

module eer_mem #(
  parameter AW = `EER_ADDR_W,
  parameter DW = `EER_DATA_W
) (
  // Clock
  input wire mclk_i,
  // Write port
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  // Read port
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);

  reg [DW-1:0] cells [0:(1<<AW)-1];

  // Registered read keeps the array mappable onto block memory.
  always @(posedge mclk_i) begin
    if (we_i) begin
      cells[waddr_i] <= wdata_i;
    end
    rdata_o <= cells[raddr_i];
  end

endmodule // eer_mem
`default_nettype wire

// >>> rtl/eer_top.v
/*
  Two-wire bus target of a serial EEPROM: control byte match, address load,
  reads (current, random, sequential), pointer and self-timed write cycle.
  Assumes the bus master drives the clock line; both bus lines and the
  chip-select pins are asynchronous and are sampled by mclk_i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eer_defs.vh"

module eer_top #(
  parameter AW = `EER_ADDR_W,
  parameter DW = `EER_DATA_W,
  parameter [3:0] DEV_CODE = 4'h5, // Arbitrary device-type code.
  parameter [`EER_TWC_W-1:0] TWC_CYC = `EER_TWC_CYC
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Serial bus
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  // Strap pins and status
  input wire [2:0] chip_select_pins_i,
  output reg busy_o
);

  // One-hot states.
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_CTRL = 6'h02;
  localparam [5:0] S_ADRH = 6'h04;
  localparam [5:0] S_ADRL = 6'h08;
  localparam [5:0] S_WR = 6'h10;
  localparam [5:0] S_RD = 6'h20;

  reg [5:0] state;
  reg [`EER_CNT_W-1:0] cnt;
  reg [DW-1:0] sh;
  reg [DW-1:0] tx;
  reg rw;
  reg mack;
  reg [AW-9:0] adr_hi;
  reg [AW-1:0] ptr;
  reg wr_pend;
  reg [AW-1:0] wr_addr;
  reg [DW-1:0] wr_data;
  reg mem_we;
  reg [`EER_TWC_W-1:0] twc;
  wire [DW-1:0] rd_data;

  // Two-stage synchronisers, then one more stage on the two bus lines for edge detection.
  reg scl_m, scl_s, scl_d;
  reg sda_m, sda_s, sda_d;
  reg [2:0] cs_m, cs_s;

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      cs_m <= 3'h0;
      cs_s <= 3'h0;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
      cs_m <= chip_select_pins_i;
      cs_s <= cs_m;
    end
  end

  // Bus conditions, seen only from the second synchroniser stage onward.
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire rx_state = |(state & (S_CTRL | S_ADRH | S_ADRL | S_WR));

  // Control byte match against the type code and the chip-select straps.
  function ctrl_match;
    input [DW-1:0] b;
    input [2:0] cs;
    begin
      ctrl_match = (b[`EER_CTRL_TYPE_HI:`EER_CTRL_TYPE_LO] == DEV_CODE) &&
                   (b[`EER_CTRL_CS_HI:`EER_CTRL_CS_LO] == cs);
    end
  endfunction

  eer_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .mclk_i(mclk_i),
    .we_i(mem_we),
    .waddr_i(wr_addr),
    .wdata_i(wr_data),
    .raddr_i(ptr),
    .rdata_o(rd_data)
  );

  // Self-timed write cycle. The array is committed once, at the Stop.
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      twc <= {`EER_TWC_W{1'b0}};
      mem_we <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      if (stop_c && wr_pend && !busy_o) begin
        mem_we <= 1'b1;
        busy_o <= 1'b1;
        twc <= TWC_CYC;
      end else if (busy_o) begin
        if (twc <= `EER_TWC_W'h1) begin
          busy_o <= 1'b0;
        end
        twc <= twc - `EER_TWC_W'h1;
      end
    end
  end

  // Protocol engine: bits shift in on clock rise, the target drives on fall.
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      cnt <= `EER_CNT_ZERO;
      sh <= {DW{1'b0}};
      tx <= {DW{1'b0}};
      rw <= 1'b0;
      mack <= 1'b0;
      adr_hi <= {(AW-8){1'b0}};
      ptr <= {AW{1'b0}};
      wr_pend <= 1'b0;
      wr_addr <= {AW{1'b0}};
      wr_data <= {DW{1'b0}};
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (start_c) begin
      // A Start always restarts at the control byte; a half-received
      // write is dropped, so a dummy write never reaches the array.
      state <= S_CTRL;
      cnt <= `EER_CNT_ZERO;
      sda_oe_o <= 1'b0;
      wr_pend <= 1'b0;
    end else if (stop_c) begin
      state <= S_IDLE;
      cnt <= `EER_CNT_ZERO;
      sda_oe_o <= 1'b0;
      wr_pend <= 1'b0;
    end else if (scl_rise && state != S_IDLE) begin
      if (cnt < `EER_BIT_ACK) begin
        sh <= {sh[DW-2:0], sda_s};
        cnt <= cnt + `EER_CNT_ONE;
      end else if (cnt == `EER_BIT_ACK) begin
        mack <= ~sda_s;
        cnt <= `EER_BIT_END;
      end
    end else if (scl_fall && state != S_IDLE) begin
      if (cnt == `EER_BIT_ACK && rx_state) begin
        // Byte complete: decide on the acknowledge and act on the byte.
        case (state)
          S_CTRL: begin
            if (ctrl_match(sh, cs_s) && !busy_o) begin
              sda_oe_o <= 1'b1;
              rw <= sh[`EER_CTRL_RW];
            end else begin
              state <= S_IDLE;
            end
          end
          S_ADRH: begin
            adr_hi <= sh[`EER_ADRH_HI:0];
            sda_oe_o <= 1'b1;
          end
          S_ADRL: begin
            ptr <= {adr_hi, sh};
            sda_oe_o <= 1'b1;
          end
          S_WR: begin
            wr_addr <= ptr;
            wr_data <= sh;
            wr_pend <= 1'b1;
            ptr <= ptr + {{(AW-1){1'b0}}, 1'b1};
            sda_oe_o <= 1'b1;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end else if (cnt == `EER_BIT_ACK) begin
        // Read: release the line for the master's acknowledge bit.
        sda_oe_o <= 1'b0;
      end else if (cnt == `EER_BIT_END) begin
        cnt <= `EER_CNT_ZERO;
        sda_oe_o <= 1'b0;
        case (state)
          S_CTRL: begin
            if (rw) begin
              state <= S_RD;
              tx <= {rd_data[DW-2:0], 1'b0};
              sda_oe_o <= ~rd_data[DW-1];
              ptr <= ptr + {{(AW-1){1'b0}}, 1'b1};
            end else begin
              state <= S_ADRH;
            end
          end
          S_ADRH: begin
            state <= S_ADRL;
          end
          S_ADRL: begin
            state <= S_WR;
          end
          S_WR: begin
            state <= S_WR;
          end
          S_RD: begin
            if (mack) begin
              // Pointer rolls from the top location to zero by width.
              tx <= {rd_data[DW-2:0], 1'b0};
              sda_oe_o <= ~rd_data[DW-1];
              ptr <= ptr + {{(AW-1){1'b0}}, 1'b1};
            end else begin
              state <= S_IDLE;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end else if (state == S_RD) begin
        // Open drain: the line is pulled low only for zero bits.
        sda_oe_o <= ~tx[DW-1];
        tx <= {tx[DW-2:0], 1'b0};
      end
    end
  end

  // After any read the pointer already points past the returned byte.

endmodule // eer_top
`default_nettype wire

// >>> testbench/eer_master.sv
/* Bus master model: Start, Stop and 9-bit slots.
   Assumes a pull-up, so a released line reads high. */
`timescale 1ns/10ps
`default_nettype none
module eer_master (
  // Clock and resolved line
  input wire mclk_i,
  input wire line_i,
  // Driven lines, 1 releases
  output logic scl_o,
  output logic sda_o
);
  // Clock stands high between frames.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Quarter period, 40 ns.
  task automatic w;
    repeat (8) @(posedge mclk_i);
  endtask
  // Also a repeated Start, or a poll resent after no ack.
  task automatic start;
    sda_o <= 1'b1;
    w();
    scl_o <= 1'b1;
    w();
    sda_o <= 1'b0;
    w();
    scl_o <= 1'b0;
    w();
  endtask
  // Stop leaves both lines released.
  task automatic stop;
    sda_o <= 1'b0;
    w();
    scl_o <= 1'b1;
    w();
    sda_o <= 1'b1;
    w();
  endtask
  // A cut byte of four bits, so that a Start or Stop lands mid-byte.
  task automatic part(input logic [3:0] tx);
    for (int i = 3; i >= 0; i--) begin
      sda_o <= tx[i];
      w();
      scl_o <= 1'b1;
      w();
      w();
      scl_o <= 1'b0;
      w();
    end
  endtask
  // Nine bits MSB first; the line is read mid-high.
  task automatic xb(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_o <= tx[i];
      w();
      scl_o <= 1'b1;
      w();
      rx[i] = line_i;
      w();
      scl_o <= 1'b0;
      w();
    end
  endtask
endmodule // eer_master
`default_nettype wire

// >>> testbench/eer_top_properties.sv
/* Port checker of the EEPROM target.
   Assumes a pulled-up data line and the bind at the foot. */
`timescale 1ns/10ps
`default_nettype none
`include "eer_defs.vh"
module eer_top_props #(
  parameter [`EER_TWC_W-1:0] TWC_CYC = 20'h00258
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Bus, straps and status
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire [2:0] chip_select_pins_i,
  input wire busy_o
);
  reg scl_d;
  reg sda_d;
  reg [7:0] since_stop;
  reg [19:0] busy_cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Raw Stop seen early, since the target adds its synchroniser lag.
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      since_stop <= 8'hFF;
      busy_cnt <= 20'h00000;
    end else begin
      scl_d <= scl_i;
      sda_d <= sda_i;
      if (scl_i && scl_d && sda_i && !sda_d) since_stop <= 8'h00;
      else if (since_stop != 8'hFF) since_stop <= since_stop + 8'h01;
      busy_cnt <= busy_o ? busy_cnt + 20'h00001 : 20'h00000;
    end
  end
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data out not low");
  busy_mute_a: assert property (busy_o |-> !sda_oe_o)
    else $error("ack while busy");
  busy_src_a: assert property ($rose(busy_o) |-> since_stop < 8'h10)
    else $error("write cycle without Stop");
  busy_len_a: assert property ($fell(busy_o) |->
    busy_cnt >= TWC_CYC - 1 && busy_cnt <= TWC_CYC + 1) else $error("write time");
  drive_low_a: assert property ($rose(sda_oe_o) |-> !scl_i ##1 !scl_i)
    else $error("drive began with clock high");
  held_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data moved with clock high");
  stop_rel_a: assert property (since_stop > 8'h04 && since_stop < 8'h3C |-> !sda_oe_o)
    else $error("line held after Stop");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |-> !sda_oe_o && !busy_o)
    else $error("active in reset");
endmodule // eer_top_props
bind eer_top eer_top_props #(.TWC_CYC(TWC_CYC)) u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .chip_select_pins_i(chip_select_pins_i), .busy_o(busy_o));
`default_nettype wire

// >>> testbench/tb_eer_top.sv
/* Self-checking bench of the EEPROM target.
   Assumes the master model and a short write time. */
`timescale 1ns/10ps
`default_nettype none
module tb_eer_top;
  localparam [19:0] TWC = 20'h00258;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b0;
  logic [2:0] cs_pins = 3'h5;
  logic [8:0] rx;
  wire scl;
  wire m_sda;
  wire sda_o;
  wire oe;
  wire busy;
  wire line = m_sda & ~(oe & ~sda_o);
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2.5 mclk_i = ~mclk_i;
  eer_top #(.DEV_CODE(4'h5), .TWC_CYC(TWC)) uut (.mclk_i(mclk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(line), .sda_o(sda_o), .sda_oe_o(oe),
    .chip_select_pins_i(cs_pins), .busy_o(busy));
  eer_master bm (.mclk_i(mclk_i), .line_i(line), .scl_o(scl), .sda_o(m_sda));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Ack of a written byte lands in rx[0], low when given.
  task automatic wb(input logic [7:0] d);
    bm.xb({d, 1'b1}, rx);
  endtask
  task automatic rb(input logic nack);
    bm.xb({8'hFF, nack}, rx);
  endtask
  task automatic t_write(input logic [15:0] a, input logic [7:0] d);
    int n;
    bm.start();
    wb(8'h5A);
    chk(rx[0], 1'b0);
    wb(a[15:8]);
    wb(a[7:0]);
    wb(d);
    bm.stop();
    n = 0;
    do begin
      bm.start();
      wb(8'h5A);
      n++;
    end while (rx[0] && n < 20);
    bm.stop();
    chk(n > 1, 1'b1);
    chk(rx[0], 1'b0);
    $display("write test done");
  endtask
  task automatic t_rand(input logic [15:0] a, input logic [7:0] e0, e1, input logic two);
    bm.start();
    wb(8'h5A);
    wb(a[15:8]);
    wb(a[7:0]);
    bm.start();
    wb(8'h5B);
    chk(rx[0], 1'b0);
    rb(~two);
    chk(rx[8:1], e0);
    if (two) begin
      rb(1'b1);
      chk(rx[8:1], e1);
    end
    chk(oe, 1'b0);
    bm.stop();
    chk(oe, 1'b0);
    chk(busy, 1'b0);
    $display("random read test done");
  endtask
  task automatic t_cur(input logic [7:0] e);
    bm.start();
    wb(8'h5B);
    chk(rx[0], 1'b0);
    rb(1'b1);
    chk(rx[8:1], e);
    chk(oe, 1'b0);
    bm.stop();
    $display("current read test done");
  endtask
  // Cut data bytes: a Stop must start no write, a Start must lose nothing.
  task automatic t_abort;
    bm.start();
    wb(8'h5A);
    wb(8'h00);
    wb(8'h00);
    bm.part(4'h1);
    bm.stop();
    chk(busy, 1'b0);
    bm.start();
    wb(8'h5A);
    wb(8'h00);
    wb(8'h00);
    bm.part(4'h1);
    t_rand(16'h0000, 8'hA5, 8'h00, 1'b0);
    $display("abort test done");
  endtask
  // A control byte for another chip-select setting is ignored.
  task automatic t_nomatch;
    bm.start();
    wb(8'h58);
    chk(rx[0], 1'b1);
    bm.stop();
    $display("chip select test done");
  endtask
  // Main sequence: reset, writes, then the read kinds.
  initial begin
    // Reset rises at time zero so the asynchronous clear beats the first edge.
    rst_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    t_write(16'hFFFF, 8'h3C);
    t_write(16'h0000, 8'hA5);
    t_rand(16'h7FFF, 8'h3C, 8'h00, 1'b0);
    t_cur(8'hA5);
    t_rand(16'h7FFF, 8'h3C, 8'hA5, 1'b1);
    t_abort();
    t_nomatch();
    finish_test();
  end
endmodule // tb_eer_top
`default_nettype wire
